// ===== hw/kpw_pkg.sv
// Constants and carrier types for the keypad wake unit.
// Assumes a 32-bit AXI4-Lite register bus on a single 25 MHz clock.
package kpw_pkg;
  localparam int unsigned NUM_KEYS = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // Printed offsets are not word aligned, so each is an index times four.
  localparam logic [ADDR_W-1:0] IDX_STATUS_CONTROL = 8'h1a;
  localparam logic [ADDR_W-1:0] IDX_PIN_ENABLES = 8'h1b;
  localparam logic [ADDR_W-1:0] IDX_BREAK_CONTROL = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS_CONTROL = IDX_STATUS_CONTROL << 2;
  localparam logic [ADDR_W-1:0] ADDR_PIN_ENABLES = IDX_PIN_ENABLES << 2;
  localparam logic [ADDR_W-1:0] ADDR_BREAK_CONTROL = IDX_BREAK_CONTROL << 2;
  // Status and control, and break control, field positions.
  localparam int unsigned BIT_LEVEL_SELECT = 0;
  localparam int unsigned BIT_REQUEST_MASK = 1;
  localparam int unsigned BIT_ACK = 2;
  localparam int unsigned BIT_PENDING = 3;
  localparam int unsigned BIT_BREAK_CLEAR = 0;
  localparam logic [NUM_KEYS-1:0] ENABLES_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic request_mask;
    logic level_select;
  } kpw_ctl_t;

  localparam kpw_ctl_t CTL_RESET = '{request_mask: 1'b0, level_select: 1'b0};
endpackage

// ===== hw/kpw_sync.sv
// Two-stage synchroniser for a bus of asynchronous inputs.
// Assumes the inputs are slow switch levels; a pulse narrower than one clock may be missed.
`timescale 1ns/1ns
`default_nettype none
module kpw_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_ff <= '1;
      o_sync  <= '1;
    end
    else
    begin
      meta_ff <= i_async;
      o_sync  <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ===== hw/kpw_key_latch.sv
// Shared keypad request latch with edge-only or edge-and-level triggering.
// Assumes synchronised pins and a one-cycle acknowledge pulse on the same clock.
`timescale 1ns/1ns
`default_nettype none
module kpw_key_latch (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_b,
  input  wire logic [kpw_pkg::NUM_KEYS-1:0] i_pins,
  input  wire logic [kpw_pkg::NUM_KEYS-1:0] i_enables,
  input  wire logic                         i_level_select,
  input  wire logic                         i_ack,
  output var  logic                         o_request,
  output logic                              o_keys_low,
  output logic                              o_event
);
  logic prev_low_ff;
  logic ack_seen_ff;
  logic nxt_request;
  logic nxt_ack_seen;
  logic ack_done;
  logic clear_now;

  assign o_keys_low = |(i_enables & ~i_pins);
  // An event needs every enabled pin high the cycle before.
  assign o_event = o_keys_low & ~prev_low_ff; // see RL12
  assign ack_done = i_ack | ack_seen_ff;
  // Level mode waits for both the acknowledge and all pins high, in either order.
  assign clear_now = i_level_select ? (ack_done & ~o_keys_low) : i_ack; // see RL13
  // A new event wins over a clear in the same cycle.
  // A low enabled pin in level mode holds the request, even after a mode change.
  assign nxt_request = o_event | (i_level_select & o_keys_low) // see RL9
                     | (o_request & ~clear_now);
  assign nxt_ack_seen = nxt_request & i_level_select & ~o_event & ack_done;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      prev_low_ff <= 1'b0;
      ack_seen_ff <= 1'b0;
      o_request   <= 1'b0;
    end
    else
    begin
      prev_low_ff <= o_keys_low;
      ack_seen_ff <= nxt_ack_seen;
      o_request   <= nxt_request;
    end
  end
endmodule
`default_nettype wire

// ===== hw/kpw_top.sv
// Keypad wake unit: eight enabled port pins feed one request latch behind AXI4-Lite.
// Assumes break state, low-power modes and vector fetch come from logic on i_clk.
//
// What this block does
// RL1 - The unit keeps running in wait mode and an unmasked request wakes the core from wait.
// RL2 - The unit keeps running in stop mode and an unmasked request wakes the core from stop.
// RL3 - With break clear enabled, an acknowledge during break clears the latch for good.
// RL4 - With break clear disabled, its reset value, a software acknowledge during break has no effect.
// RL5 - The upper four status and control bits read as zero and ignore writes.
// RL6 - The pending flag shows the latch, is cleared by reset and ignores the mask.
// RL7 - Writing one to the acknowledge bit clears the request and the bit reads as zero.
// RL8 - The mask bit blocks the request to the core when set and resets to zero.
// RL9 - The level select bit picks edges and low levels when set, edges only when clear.
// RL10 - Each of the eight enable bits lets its pin latch requests and all reset to zero.
// RL11 - Software may drive pins high as outputs before enabling them to avoid false requests.
// RL12 - In edge mode a fall is ignored while another enabled pin is low, and acknowledge clears at once.
// RL13 - In level mode the request clears only after acknowledge and all enabled pins high.
// RL14 - An enabled pin is forced to be an input whatever its direction setting.
// RL15 - Each pin passes two flip-flops before edge detection.
`timescale 1ns/1ns
`default_nettype none
module kpw_top (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_b,
  input  wire logic [kpw_pkg::NUM_KEYS-1:0] i_port_a_pin,
  input  wire logic                         i_break_state,
  input  wire logic                         i_wait_mode,
  input  wire logic                         i_stop_mode,
  input  wire logic                         i_vector_fetch,
  output var  logic                         o_cpu_irq,
  output var  logic                         o_wake,
  output var  logic [kpw_pkg::NUM_KEYS-1:0] o_pin_force_input,
  input  wire logic [kpw_pkg::ADDR_W-1:0]   i_s_awaddr,
  input  wire logic                         i_s_awvalid,
  output var  logic                         o_s_awready,
  input  wire logic [kpw_pkg::DATA_W-1:0]   i_s_wdata,
  input  wire logic [3:0]                   i_s_wstrb,
  input  wire logic                         i_s_wvalid,
  output var  logic                         o_s_wready,
  output var  logic [1:0]                   o_s_bresp,
  output var  logic                         o_s_bvalid,
  input  wire logic                         i_s_bready,
  input  wire logic [kpw_pkg::ADDR_W-1:0]   i_s_araddr,
  input  wire logic                         i_s_arvalid,
  output var  logic                         o_s_arready,
  output var  logic [kpw_pkg::DATA_W-1:0]   o_s_rdata,
  output var  logic [1:0]                   o_s_rresp,
  output var  logic                         o_s_rvalid,
  input  wire logic                         i_s_rready
);
  kpw_pkg::kpw_ctl_t                ctl_ff;
  logic [kpw_pkg::NUM_KEYS-1:0]     en_ff;
  logic                             break_clear_ff;
  logic [kpw_pkg::ADDR_W-1:0]       awaddr_ff;
  logic                             aw_held_ff;
  logic [kpw_pkg::DATA_W-1:0]       wdata_ff;
  logic                             wstrb0_ff;
  logic                             w_held_ff;
  logic                             rd_status_ff;
  logic [kpw_pkg::NUM_KEYS-1:0]     pins_sync;
  logic                             request;
  logic                             keys_low;
  logic                             key_event;

  // Address decode and strobes.
  wire do_write = aw_held_ff & w_held_ff & ~o_s_bvalid;
  wire wr_ok = do_write & wstrb0_ff;
  wire wr_status = wr_ok & (awaddr_ff == kpw_pkg::ADDR_STATUS_CONTROL);
  wire wr_enables = wr_ok & (awaddr_ff == kpw_pkg::ADDR_PIN_ENABLES);
  wire wr_break = wr_ok & (awaddr_ff == kpw_pkg::ADDR_BREAK_CONTROL);
  wire wr_hit = (awaddr_ff == kpw_pkg::ADDR_STATUS_CONTROL)
              | (awaddr_ff == kpw_pkg::ADDR_PIN_ENABLES)
              | (awaddr_ff == kpw_pkg::ADDR_BREAK_CONTROL);
  wire aw_take = i_s_awvalid & o_s_awready;
  wire w_take = i_s_wvalid & o_s_wready;
  wire ar_take = i_s_arvalid & o_s_arready;
  wire rd_status = i_s_araddr == kpw_pkg::ADDR_STATUS_CONTROL;
  wire rd_enables = i_s_araddr == kpw_pkg::ADDR_PIN_ENABLES;
  wire rd_break = i_s_araddr == kpw_pkg::ADDR_BREAK_CONTROL;
  wire rd_hit = rd_status | rd_enables | rd_break;

  // The acknowledge bit is never stored, so it reads back as zero.
  wire ack_write = wr_status & wdata_ff[kpw_pkg::BIT_ACK]; // see RL7
  // During break a software acknowledge only counts when break clear is enabled.
  wire ack_allowed = ~i_break_state | break_clear_ff; // see RL3 see RL4
  wire ack_pulse = (ack_write & ack_allowed) | i_vector_fetch;

  // Upper nibble and the acknowledge position are hard zero.
  wire [kpw_pkg::DATA_W-1:0] status_word = {28'h000_0000, request, 1'b0, // see RL5 see RL6
                                            ctl_ff.request_mask, ctl_ff.level_select};
  wire [kpw_pkg::DATA_W-1:0] enables_word = {24'h00_0000, en_ff};
  wire [kpw_pkg::DATA_W-1:0] break_word = {31'h0000_0000, break_clear_ff};
  wire [kpw_pkg::DATA_W-1:0] rd_word = rd_status ? status_word
                                     : rd_enables ? enables_word
                                     : rd_break ? break_word : kpw_pkg::DATA_ZERO;

  kpw_sync #(
    .WIDTH (kpw_pkg::NUM_KEYS)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async (i_port_a_pin), // see RL15
    .o_sync  (pins_sync)
  );

  // The latch is never gated by wait or stop, so it can wake the core.
  kpw_key_latch u_latch (
    .i_clk          (i_clk),
    .i_rst_b        (i_rst_b),
    .i_pins         (pins_sync),
    .i_enables      (en_ff), // see RL10
    .i_level_select (ctl_ff.level_select), // see RL9
    .i_ack          (ack_pulse),
    .o_request      (request),
    .o_keys_low     (keys_low),
    .o_event        (key_event)
  );

  // Write address and data channels are taken independently.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      aw_held_ff  <= 1'b0;
      awaddr_ff   <= '0;
      o_s_awready <= 1'b0;
    end
    else
    begin
      aw_held_ff  <= aw_take | (aw_held_ff & ~do_write);
      o_s_awready <= ~(aw_take | (aw_held_ff & ~do_write)) & ~o_s_bvalid & ~do_write;
      if (aw_take)
        awaddr_ff <= i_s_awaddr;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      w_held_ff  <= 1'b0;
      wdata_ff   <= '0;
      wstrb0_ff  <= 1'b0;
      o_s_wready <= 1'b0;
    end
    else
    begin
      w_held_ff  <= w_take | (w_held_ff & ~do_write);
      o_s_wready <= ~(w_take | (w_held_ff & ~do_write)) & ~o_s_bvalid & ~do_write;
      if (w_take)
      begin
        wdata_ff  <= i_s_wdata;
        wstrb0_ff <= i_s_wstrb[0];
      end
    end
  end

  // Unmapped addresses answer SLVERR; a write with lane 0 off is accepted and ignored.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_s_bvalid <= 1'b0;
      o_s_bresp  <= kpw_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      o_s_bvalid <= 1'b1;
      o_s_bresp  <= wr_hit ? kpw_pkg::RESP_OKAY : kpw_pkg::RESP_SLVERR;
    end
    else if (i_s_bready)
      o_s_bvalid <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_s_arready  <= 1'b0;
      o_s_rvalid   <= 1'b0;
      o_s_rdata    <= kpw_pkg::DATA_ZERO;
      o_s_rresp    <= kpw_pkg::RESP_OKAY;
      rd_status_ff <= 1'b0;
    end
    else if (ar_take)
    begin
      o_s_arready  <= 1'b0;
      o_s_rvalid   <= 1'b1;
      o_s_rdata    <= rd_word;
      o_s_rresp    <= rd_hit ? kpw_pkg::RESP_OKAY : kpw_pkg::RESP_SLVERR;
      rd_status_ff <= rd_status;
    end
    else if (o_s_rvalid)
    begin
      o_s_rvalid  <= ~i_s_rready;
      o_s_arready <= i_s_rready;
    end
    else
      o_s_arready <= 1'b1;
  end

  // Control registers.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ctl_ff  <= kpw_pkg::CTL_RESET; // see RL8 see RL9
      en_ff   <= kpw_pkg::ENABLES_RESET; // see RL10
      break_clear_ff <= 1'b0; // see RL4
    end
    else
    begin
      if (wr_status)
      begin
        ctl_ff.request_mask <= wdata_ff[kpw_pkg::BIT_REQUEST_MASK]; // see RL8
        ctl_ff.level_select <= wdata_ff[kpw_pkg::BIT_LEVEL_SELECT]; // see RL9
      end
      if (wr_enables)
        en_ff <= wdata_ff[kpw_pkg::NUM_KEYS-1:0];
      if (wr_break)
        break_clear_ff <= wdata_ff[kpw_pkg::BIT_BREAK_CLEAR];
    end
  end

  // Core request, wake and pin direction override.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_cpu_irq         <= 1'b0;
      o_wake            <= 1'b0;
      o_pin_force_input <= '0;
    end
    else
    begin
      o_cpu_irq         <= request & ~ctl_ff.request_mask; // see RL8
      o_wake            <= request & ~ctl_ff.request_mask // see RL1 see RL2
                           & (i_wait_mode | i_stop_mode);
      o_pin_force_input <= en_ff; // see RL14
    end
  end

  // Checks. The latch sits one stage inside, so relations look one edge ahead.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_status_upper_zero: assert property ( // see RL5
    o_s_rvalid && rd_status_ff |-> o_s_rdata[7:4] == 4'h0)
    else $error("status upper bits not zero");
  a_ack_reads_zero: assert property ( // see RL7
    o_s_rvalid && rd_status_ff |-> !o_s_rdata[kpw_pkg::BIT_ACK])
    else $error("acknowledge bit read as one");
  a_mask_blocks_irq: assert property ( // see RL8
    ctl_ff.request_mask |=> !o_cpu_irq)
    else $error("masked request reached core");
  a_wake_from_wait: assert property ( // see RL1
    request && !ctl_ff.request_mask && i_wait_mode |=> o_wake && o_cpu_irq)
    else $error("no wake from wait");
  a_wake_from_stop: assert property ( // see RL2
    request && !ctl_ff.request_mask && i_stop_mode |=> o_wake)
    else $error("no wake from stop");
  a_break_protects: assert property ( // see RL4
    ack_write && i_break_state && !break_clear_ff && !i_vector_fetch && request
    && (!ctl_ff.level_select || keys_low) |=> request)
    else $error("acknowledge took effect in protected break");
  a_break_clears: assert property ( // see RL3
    ack_write && i_break_state && break_clear_ff && !ctl_ff.level_select && !key_event
    && !wdata_ff[kpw_pkg::BIT_LEVEL_SELECT]
    |=> !request ##1 (!request || $past(key_event)))
    else $error("break acknowledge did not clear latch");
  a_edge_ack_clears: assert property ( // see RL12
    !ctl_ff.level_select && ack_pulse && !key_event |=> !request)
    else $error("edge mode acknowledge did not clear");
  a_level_holds: assert property ( // see RL13
    ctl_ff.level_select && keys_low && request |=> request)
    else $error("level request cleared while pin low");
  a_pending_shows_latch: assert property ( // see RL6
    ar_take && rd_status |=> o_s_rdata[kpw_pkg::BIT_PENDING] == $past(request))
    else $error("pending flag does not show the latch");
  a_pin_forced_input: assert property ( // see RL14
    1'b1 |=> o_pin_force_input == $past(en_ff))
    else $error("enabled pin not forced to input");
  a_irq_follows_latch: assert property ( // see RL8
    request && !ctl_ff.request_mask |=> o_cpu_irq)
    else $error("unmasked request did not reach core");
  a_irq_idle_low: assert property ( // see RL8
    !request |=> !o_cpu_irq)
    else $error("core request without latched request");
  a_mask_blocks_wake: assert property ( // see RL1 see RL2
    ctl_ff.request_mask |=> !o_wake)
    else $error("masked request woke the core");
  a_wake_needs_mode: assert property ( // see RL1 see RL2
    !i_wait_mode && !i_stop_mode |=> !o_wake)
    else $error("wake raised outside wait and stop");
  a_event_needs_enable: assert property ( // see RL10
    key_event |-> |(en_ff & ~pins_sync))
    else $error("event from a pin that is not enabled");
  a_edge_blocked_low: assert property ( // see RL12
    $past(keys_low) |-> !key_event)
    else $error("event while an enabled pin was already low");
  a_edge_request_holds: assert property ( // see RL12
    !ctl_ff.level_select && request && !ack_pulse |=> request)
    else $error("edge mode request lost without acknowledge");
  a_level_low_sets: assert property ( // see RL9
    ctl_ff.level_select && keys_low |=> request)
    else $error("low level did not hold a request");
  a_vector_clears: assert property ( // see RL12
    !ctl_ff.level_select && i_vector_fetch && !key_event |=> !request)
    else $error("vector fetch did not clear edge request");
  a_enables_write: assert property ( // see RL10
    wr_enables |=> en_ff == $past(wdata_ff[kpw_pkg::NUM_KEYS-1:0]))
    else $error("enable write did not land");
  a_mask_write: assert property ( // see RL8
    wr_status |=> ctl_ff.request_mask == $past(wdata_ff[kpw_pkg::BIT_REQUEST_MASK]))
    else $error("mask write did not land");
  a_level_write: assert property ( // see RL9
    wr_status |=> ctl_ff.level_select == $past(wdata_ff[kpw_pkg::BIT_LEVEL_SELECT]))
    else $error("level select write did not land");
  a_break_clear_write: assert property ( // see RL3
    wr_break |=> break_clear_ff == $past(wdata_ff[kpw_pkg::BIT_BREAK_CLEAR]))
    else $error("break clear write did not land");
  // Bus handshake checks.
  a_write_busy_refuse: assert property (
    o_s_bvalid |-> !o_s_awready && !o_s_wready)
    else $error("write channel ready while response waits");
  a_read_busy_refuse: assert property (
    o_s_rvalid |-> !o_s_arready)
    else $error("read address ready while read data waits");
  a_bresp_holds: assert property (
    o_s_bvalid && !i_s_bready |=> o_s_bvalid && $stable(o_s_bresp))
    else $error("write response dropped before it was taken");
  a_rdata_holds: assert property (
    o_s_rvalid && !i_s_rready |=> o_s_rvalid && $stable(o_s_rdata))
    else $error("read data dropped before it was taken");
  a_unmapped_read_zero: assert property (
    o_s_rvalid && o_s_rresp == kpw_pkg::RESP_SLVERR |-> o_s_rdata == kpw_pkg::DATA_ZERO)
    else $error("unmapped read returned data");

  c_write_ack: cover property (ack_write ##1 !request);
  c_level_wait: cover property (ctl_ff.level_select && ack_pulse && keys_low ##[1:20] !request);
  c_wake: cover property (i_stop_mode && o_wake);
  c_break_protect: cover property (ack_write && i_break_state && !break_clear_ff && request);
  c_edge_masked_fall: cover property ($changed(pins_sync) && $past(keys_low) && keys_low);
endmodule
`default_nettype wire

// ===== test/kpw_keys.sv
// Behavioural key switches that stand on the eight port pins.
// Assumes the enable copy from the unit switches each pin's pull-up on.
`timescale 1ns/1ns
`default_nettype none
module kpw_keys (
  input  wire logic [kpw_pkg::NUM_KEYS-1:0] i_pressed,
  input  wire logic [kpw_pkg::NUM_KEYS-1:0] i_pullup_en,
  input  wire logic [kpw_pkg::NUM_KEYS-1:0] i_port_out,
  output var  logic [kpw_pkg::NUM_KEYS-1:0] o_pins
);
  // A pressed key grounds its pin and an enabled pin rises on its pull-up.
  // A pin that is neither shows what the port drives, so a careless enable may latch.
  assign o_pins = ~i_pressed & (i_pullup_en | i_port_out);
endmodule
`default_nettype wire

// ===== test/keypad_pin_interrupt_bench.sv
// Self-checking bench for the keypad wake unit through its register bus.
// Assumes the package, the design files and the key model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module keypad_pin_interrupt_bench;
  localparam logic [7:0] SC = kpw_pkg::ADDR_STATUS_CONTROL;
  localparam logic [7:0] EN = kpw_pkg::ADDR_PIN_ENABLES;
  localparam logic [7:0] BC = kpw_pkg::ADDR_BREAK_CONTROL;
  logic        clk, rst_b, brk, wait_m, stop_m, vfetch, irq, wake;
  logic [7:0]  pressed, port_out, pins, force_in, awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, data;
  logic [1:0]  bresp, rresp, resp;
  int          errors;
  int          compares;

  kpw_keys KEYS (.i_pressed(pressed), .i_pullup_en(force_in), .i_port_out(port_out),
    .o_pins(pins));
  kpw_top DUT (.i_clk(clk), .i_rst_b(rst_b), .i_port_a_pin(pins), .i_break_state(brk),
    .i_wait_mode(wait_m), .i_stop_mode(stop_m), .i_vector_fetch(vfetch), .o_cpu_irq(irq),
    .o_wake(wake), .o_pin_force_input(force_in), .i_s_awaddr(awaddr),
    .i_s_awvalid(awvalid), .o_s_awready(awready), .i_s_wdata(wdata), .i_s_wstrb(4'hf),
    .i_s_wvalid(wvalid), .o_s_wready(wready), .o_s_bresp(bresp), .o_s_bvalid(bvalid),
    .i_s_bready(bready), .i_s_araddr(araddr), .i_s_arvalid(arvalid),
    .o_s_arready(arready), .o_s_rdata(rdata), .o_s_rresp(rresp), .o_s_rvalid(rvalid),
    .i_s_rready(rready));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic close_out;
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Address and data are offered together and each is dropped once it is taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Only the watchdog ends a wait that never sees the response.
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(data, {24'h00_0000, e});
  endtask

  // Six edges cover two sync stages, the latch and the registered request.
  task automatic key(input logic [7:0] p);
    @(posedge clk);
    pressed <= p;
    repeat (6) @(posedge clk);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out;
  end

  initial
  begin
    errors = 0;
    compares = 0;
    rst_b = 1'b0;
    pressed = 8'h00;
    port_out = 8'hff;
    {brk, wait_m, stop_m, vfetch} = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rchk(SC, 8'h00);
    rchk(EN, 8'h00);
    rchk(BC, 8'h00);
    rd(8'h74);
    chk(32'(resp), 32'(kpw_pkg::RESP_SLVERR));
    chk(data, kpw_pkg::DATA_ZERO);
    wr(8'h74, 8'hff);
    chk(32'(resp), 32'(kpw_pkg::RESP_SLVERR));
    wr(SC, 8'hff);
    rchk(SC, 8'h03);
    wr(SC, 8'h00);
    // Each enable alone: a pin that is not enabled must stay silent.
    for (int i = 0; i < 8; i++)
    begin
      wr(EN, 8'h01 << i);
      key(8'h01 << ((i + 1) % 8));
      chk(32'(force_in), 32'(8'h01 << i));
      rchk(SC, 8'h00);
      key(8'h01 << i);
      rchk(SC, 8'h08);
      chk(32'(irq), 32'h0000_0001);
      wr(SC, 8'h04);
      rchk(SC, 8'h00);
      key(8'h00);
    end
    wr(EN, 8'h03);
    key(8'h01);
    wr(SC, 8'h04);
    key(8'h03);
    rchk(SC, 8'h00);
    key(8'h00);
    wr(EN, 8'h01);
    wr(SC, 8'h02);
    key(8'h01);
    rchk(SC, 8'h0a);
    wait_m <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'({irq, wake}), 32'h0000_0000);
    wr(SC, 8'h00);
    repeat (2) @(posedge clk);
    chk(32'({irq, wake}), 32'h0000_0003);
    wait_m <= 1'b0;
    stop_m <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(wake), 32'h0000_0001);
    stop_m <= 1'b0;
    brk <= 1'b1;
    wr(SC, 8'h04);
    rchk(SC, 8'h08);
    wr(BC, 8'h01);
    wr(SC, 8'h04);
    rchk(SC, 8'h00);
    brk <= 1'b0;
    rchk(SC, 8'h00);
    rchk(BC, 8'h01);
    chk(32'(wake), 32'h0000_0000);
    wr(BC, 8'h00);
    key(8'h00);
    // Level mode needs both the acknowledge and the pins high, in either order.
    wr(SC, 8'h01);
    key(8'h01);
    wr(SC, 8'h05);
    rchk(SC, 8'h09);
    key(8'h00);
    rchk(SC, 8'h01);
    key(8'h01);
    key(8'h00);
    rchk(SC, 8'h09);
    @(posedge clk);
    vfetch <= 1'b1;
    @(posedge clk);
    vfetch <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(SC, 8'h01);
    close_out;
  end
endmodule
`default_nettype wire
